//--- cfbu_defs.svh
// Offsets, field positions, reset values and cycle counts of the flow-control unit.
`ifndef CFBU_DEFS_SVH
`define CFBU_DEFS_SVH

`define CFBU_OFF_CTRL      8'h00
`define CFBU_OFF_INSTR     8'h04
`define CFBU_OFF_TARGET    8'h08
`define CFBU_OFF_PC        8'h0c
`define CFBU_OFF_OPND      8'h10
`define CFBU_OFF_ZPTR      8'h14
`define CFBU_OFF_FLAGS     8'h18
`define CFBU_OFF_STATUS    8'h1c

`define CFBU_CTRL_START    0
`define CFBU_INSTR_NEXT2   16

`define CFBU_FLG_C         0
`define CFBU_FLG_Z         1
`define CFBU_FLG_N         2
`define CFBU_FLG_V         3
`define CFBU_FLG_S         4
`define CFBU_FLG_H         5
`define CFBU_FLG_T         6
`define CFBU_FLG_I         7

`define CFBU_ST_BUSY       0
`define CFBU_ST_DONE       1
`define CFBU_ST_HIT        2
`define CFBU_ST_ILLEGAL    3

`define CFBU_RST_PC        16'h0000
`define CFBU_RST_FLAGS     8'h00
`define CFBU_RST_WORD      32'h0000_0000

`define CFBU_CYC_ONE       3'h1
`define CFBU_CYC_BRANCH    3'h2
`define CFBU_CYC_SKIP1     3'h2
`define CFBU_CYC_SKIP2     3'h3
`define CFBU_CYC_RELATIVE_CALL     3'h3
`define CFBU_CYC_ZCALL     3'h3
`define CFBU_CYC_DCALL     3'h4
`define CFBU_CYC_RET       3'h4

`define CFBU_RESP_OKAY     2'h0
`define CFBU_RESP_SLVERR   2'h2

`endif

//--- cfbu_pkg.sv
// Types shared by the flow-control unit.
package cfbu_pkg;

   typedef enum logic [1:0] {
      CFBU_IDLE = 2'b01,
      CFBU_RUN  = 2'b10
   } cfbu_state_t;

endpackage

//--- cfbu_stack_mem.sv
// Return-address stack memory with registered read data.
`timescale 1ns/10ps
module cfbu_stack_mem
   import cfbu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  waddr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic [3:0]  raddr_i,
   output logic      [15:0] rdata_o
);

   logic [15:0] mem_r [0:15];

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

   // No reset: contents are only meaningful after a push.
   always_ff @(posedge clk_i)
   begin
      rdata_o <= mem_r[raddr_i];
   end

endmodule

//--- cfbu_top.sv
// Flow-control unit: calls, returns, compares, skips and flag branches over AXI4-Lite.
// Operation
// - Calls jump relative, via pointer, or direct; 3/3/4.
// - Compares set Z N V C H, no write, 1.
// - Equal compare skips next; flags stay unchanged.
// - Register bit test skips on clear or set.
// - I/O bit test skips on clear or set.
// - Taken skip adds 2 or 3 words.
// - Generic branch selects flag, tests set or clear.
// - Taken branch adds offset plus one, 2; else 1.
// - Dedicated branches test zero, carry, negative flags.
// - Same-or-higher equals carry clear; lower equals set.
// - Signed branches use negative XOR overflow.
// - Half-carry branches test H one or zero.
// - Transfer-bit branches test T one or zero.
`timescale 1ns/10ps
`include "cfbu_defs.svh"
module cfbu_top
   import cfbu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i
);

   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        wr_fire;
   logic        wr_hit;
   logic [31:0] wmask;
   logic [31:0] instr_r;
   logic [31:0] target_r;
   logic [15:0] pc_r;
   logic [31:0] opnd_r;
   logic [15:0] zptr_r;
   logic [7:0]  flags_r;
   logic        done_r;
   logic        hit_r;
   logic        illegal_r;
   logic [2:0]  cyc_r;
   logic [2:0]  cnt_r;
   logic [3:0]  sp_r;
   cfbu_state_t state_r;
   logic        start;
   logic        commit;
   logic [15:0] stack_rdata;
   logic [31:0] rd_mux;
   logic        rd_ok;
   logic [15:0] res_pc;
   logic [15:0] res_pc_r;
   logic [7:0]  res_flags;
   logic [7:0]  res_flags_r;
   logic [2:0]  cycles;
   logic        push;
   logic        pop;
   logic        pop_r;
   logic        set_i;
   logic        set_i_r;
   logic [15:0] ret_addr;
   logic        hit;
   logic        illegal;
   logic [7:0]  cmp_a;
   logic [7:0]  cmp_b;
   logic        cmp_cin;
   logic [7:0]  diff;
   logic [7:0]  fsel;
   logic        cond;
   logic [15:0] skip_pc;
   logic [2:0]  skip_cyc;

   assign wr_fire = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_strb
         assign wmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
      end
   endgenerate

   always_comb
   begin
      wr_hit = 1'b1;
      unique case (aw_addr_r)
         `CFBU_OFF_CTRL, `CFBU_OFF_INSTR, `CFBU_OFF_TARGET, `CFBU_OFF_PC,
         `CFBU_OFF_OPND, `CFBU_OFF_ZPTR, `CFBU_OFF_FLAGS, `CFBU_OFF_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Address and data are taken independently; the write happens once both are held.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `CFBU_RESP_OKAY;
         aw_addr_r       <= 8'h00;
         w_data_r        <= `CFBU_RST_WORD;
         w_strb_r        <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_addr_r       <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_data_r       <= s_axi_wdata_i;
            w_strb_r       <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? `CFBU_RESP_OKAY : `CFBU_RESP_SLVERR;
         end
         if (s_axi_bvalid_o && s_axi_bready_i)
         begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   // Operand registers are frozen while an instruction runs, so a late write cannot tear it.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         instr_r  <= `CFBU_RST_WORD;
         target_r <= `CFBU_RST_WORD;
         opnd_r   <= `CFBU_RST_WORD;
         zptr_r   <= `CFBU_RST_PC;
      end
      else if (wr_fire && state_r == CFBU_IDLE)
      begin
         unique case (aw_addr_r)
            `CFBU_OFF_INSTR:  instr_r  <= (instr_r & ~wmask) | (w_data_r & wmask);
            `CFBU_OFF_TARGET: target_r <= (target_r & ~wmask) | (w_data_r & wmask);
            `CFBU_OFF_OPND:   opnd_r   <= (opnd_r & ~wmask) | (w_data_r & wmask);
            `CFBU_OFF_ZPTR:   zptr_r   <= (zptr_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
            default:          ;
         endcase
      end
   end

   assign start = wr_fire && state_r == CFBU_IDLE && aw_addr_r == `CFBU_OFF_CTRL
                  && w_strb_r[0] && w_data_r[`CFBU_CTRL_START];
   assign commit = state_r == CFBU_RUN && cnt_r == 3'd1;

   // Subtraction for the flag-setting compares (the equal compare tests equality); no register is ever written with the result.
   always_comb
   begin
      cmp_a   = opnd_r[7:0];
      cmp_b   = (instr_r[15:12] == 4'h3) ? {instr_r[11:8], instr_r[3:0]} : opnd_r[15:8];
      cmp_cin = (instr_r[15:10] == 6'b000001) ? flags_r[`CFBU_FLG_C] : 1'b0;
      diff    = cmp_a - cmp_b - {7'h00, cmp_cin};
   end

   // The S slot carries N xor V directly, so signed branches never trust a stale S.
   assign fsel = {flags_r[7:5], flags_r[`CFBU_FLG_N] ^ flags_r[`CFBU_FLG_V], flags_r[3:0]};
   assign cond = fsel[instr_r[2:0]];
   assign skip_pc  = pc_r + (instr_r[`CFBU_INSTR_NEXT2] ? 16'h0003 : 16'h0002);
   assign skip_cyc = instr_r[`CFBU_INSTR_NEXT2] ? `CFBU_CYC_SKIP2 : `CFBU_CYC_SKIP1;

   always_comb
   begin
      res_pc    = pc_r + 16'h0001;
      res_flags = flags_r;
      cycles    = `CFBU_CYC_ONE;
      push      = 1'b0;
      pop       = 1'b0;
      set_i     = 1'b0;
      ret_addr  = pc_r + 16'h0001;
      hit       = 1'b0;
      illegal   = 1'b0;
      casez (instr_r[15:0])
         16'b1101_????_????_????:
         begin
            res_pc = pc_r + {{4{instr_r[11]}}, instr_r[11:0]} + 16'h0001;
            cycles = `CFBU_CYC_RELATIVE_CALL;
            push   = 1'b1;
         end
         16'b1001_0101_0000_1001:
         begin
            res_pc = zptr_r;
            cycles = `CFBU_CYC_ZCALL;
            push   = 1'b1;
         end
         16'b1001_010?_????_111?:
         begin
            res_pc   = target_r[15:0];
            cycles   = `CFBU_CYC_DCALL;
            push     = 1'b1;
            ret_addr = pc_r + 16'h0002;
         end
         16'b1001_0101_0000_1000:
         begin
            cycles = `CFBU_CYC_RET;
            pop    = 1'b1;
         end
         16'b1001_0101_0001_1000:
         begin
            cycles = `CFBU_CYC_RET;
            pop    = 1'b1;
            set_i  = 1'b1;
         end
         16'b0001_00??_????_????:
         begin
            hit = opnd_r[7:0] == opnd_r[15:8];
         end
         16'b0000_01??_????_????, 16'b0001_01??_????_????, 16'b0011_????_????_????:
         begin
            res_flags[`CFBU_FLG_N] = diff[7];
            res_flags[`CFBU_FLG_Z] = (diff == 8'h00)
                                     && (flags_r[`CFBU_FLG_Z] || instr_r[12]);
            res_flags[`CFBU_FLG_V] = (cmp_a[7] & ~cmp_b[7] & ~diff[7])
                                     | (~cmp_a[7] & cmp_b[7] & diff[7]);
            res_flags[`CFBU_FLG_C] = (~cmp_a[7] & cmp_b[7]) | (cmp_b[7] & diff[7])
                                     | (diff[7] & ~cmp_a[7]);
            res_flags[`CFBU_FLG_H] = (~cmp_a[3] & cmp_b[3]) | (cmp_b[3] & diff[3])
                                     | (diff[3] & ~cmp_a[3]);
            res_flags[`CFBU_FLG_S] = res_flags[`CFBU_FLG_N] ^ res_flags[`CFBU_FLG_V];
         end
         16'b1111_11??_????_0???:
         begin
            hit = opnd_r[instr_r[2:0]] == instr_r[9];
         end
         16'b1001_10?1_????_????:
         begin
            hit = opnd_r[16 + {29'h0, instr_r[2:0]}] == instr_r[9];
         end
         16'b1111_0???_????_????:
         begin
            hit = cond ^ instr_r[10];
            if (hit)
            begin
               res_pc = pc_r + {{9{instr_r[9]}}, instr_r[9:3]} + 16'h0001;
               cycles = `CFBU_CYC_BRANCH;
            end
         end
         default:
         begin
            illegal = 1'b1;
         end
      endcase
      // Skips share one exit: only the program counter and the time change.
      if (hit && (instr_r[15:12] != 4'hf || instr_r[11]))
      begin
         res_pc = skip_pc;
         cycles = skip_cyc;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r     <= CFBU_IDLE;
         cnt_r       <= 3'd0;
         cyc_r       <= 3'd0;
         res_pc_r    <= `CFBU_RST_PC;
         res_flags_r <= `CFBU_RST_FLAGS;
         pop_r       <= 1'b0;
         set_i_r     <= 1'b0;
         hit_r       <= 1'b0;
         illegal_r   <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            CFBU_IDLE:
            begin
               if (start)
               begin
                  state_r     <= CFBU_RUN;
                  cnt_r       <= cycles;
                  cyc_r       <= cycles;
                  res_pc_r    <= res_pc;
                  res_flags_r <= res_flags;
                  pop_r       <= pop;
                  set_i_r     <= set_i;
                  hit_r       <= hit;
                  illegal_r   <= illegal;
               end
            end
            CFBU_RUN:
            begin
               cnt_r <= cnt_r - 3'd1;
               if (commit)
               begin
                  state_r <= CFBU_IDLE;
               end
            end
         endcase
      end
   end

   // Program counter and flags move at the last cycle of an instruction, or on a bus write while idle.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pc_r    <= `CFBU_RST_PC;
         flags_r <= `CFBU_RST_FLAGS;
      end
      else if (commit)
      begin
         pc_r    <= pop_r ? stack_rdata : res_pc_r;
         flags_r <= res_flags_r | (set_i_r ? 8'h80 : 8'h00);
      end
      else if (wr_fire && state_r == CFBU_IDLE)
      begin
         if (aw_addr_r == `CFBU_OFF_PC)
         begin
            pc_r <= (pc_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
         end
         if (aw_addr_r == `CFBU_OFF_FLAGS && w_strb_r[0])
         begin
            flags_r <= w_data_r[7:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         done_r <= 1'b0;
         sp_r   <= 4'h0;
      end
      else
      begin
         if (start)
         begin
            done_r <= 1'b0;
            sp_r   <= push ? sp_r + 4'h1 : (pop ? sp_r - 4'h1 : sp_r);
         end
         else if (commit)
         begin
            done_r <= 1'b1;
         end
      end
   end

   // The stack wraps after sixteen nested calls; deeper nesting overwrites the oldest entry.
   cfbu_stack_mem u_stack (
      .clk_i   (clk_i),
      .we_i    (start & push),
      .waddr_i (sp_r),
      .wdata_i (ret_addr),
      .raddr_i (sp_r),
      .rdata_o (stack_rdata)
   );

   always_comb
   begin
      rd_ok  = 1'b1;
      rd_mux = `CFBU_RST_WORD;
      unique case (s_axi_araddr_i)
         `CFBU_OFF_CTRL:   rd_mux = `CFBU_RST_WORD;
         `CFBU_OFF_INSTR:  rd_mux = instr_r;
         `CFBU_OFF_TARGET: rd_mux = target_r;
         `CFBU_OFF_PC:     rd_mux = {16'h0000, pc_r};
         `CFBU_OFF_OPND:   rd_mux = opnd_r;
         `CFBU_OFF_ZPTR:   rd_mux = {16'h0000, zptr_r};
         `CFBU_OFF_FLAGS:  rd_mux = {24'h000000, flags_r};
         `CFBU_OFF_STATUS: rd_mux = {12'h000, sp_r, 5'h00, cyc_r, 4'h0, illegal_r, hit_r,
                                     done_r, state_r == CFBU_RUN};
         default:
         begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= `CFBU_RST_WORD;
         s_axi_rresp_o   <= `CFBU_RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= rd_mux;
         s_axi_rresp_o   <= rd_ok ? `CFBU_RESP_OKAY : `CFBU_RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
      end
   end

endmodule

//--- cfbu_top_sva.sv
// Register-bus protocol checker for the flow-control unit.
`timescale 1ns/10ps
`include "cfbu_defs.svh"
module cfbu_top_sva
   import cfbu_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   input wire logic [7:0]  s_axi_awaddr_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0]  s_axi_wstrb_i,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic [7:0]  s_axi_araddr_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0]  s_axi_rresp_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_wr_take;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence s_b_wait;
      !s_axi_bvalid_o ##1 s_axi_bvalid_o;
   endsequence
   property p_b_after;
      s_wr_take |=> s_b_wait;
   endproperty
   a_b_after: assert property (p_b_after) else $error("write response late");
   property p_aw_drop;
      s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
   endproperty
   a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
   property p_b_hold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response not held");
   property p_b_ret;
      s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
   endproperty
   a_b_ret: assert property (p_b_ret) else $error("write channel not reopened");
   property p_ar;
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
   endproperty
   a_ar: assert property (p_ar) else $error("read data late");
   property p_r_hold;
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_r_ret;
      s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
   endproperty
   a_r_ret: assert property (p_r_ret) else $error("read channel not reopened");
   property p_slverr;
      s_axi_rvalid_o && s_axi_rresp_o == `CFBU_RESP_SLVERR |-> s_axi_rdata_o == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr) else $error("refused read carries data");
   property p_bresp;
      s_axi_bvalid_o |-> s_axi_bresp_o inside {`CFBU_RESP_OKAY, `CFBU_RESP_SLVERR};
   endproperty
   a_bresp: assert property (p_bresp) else $error("illegal write response");
endmodule
bind cfbu_top cfbu_top_sva u_sva (.*);

//--- cfbu_axi_master.sv
// Register-bus master model driving the flow-control unit.
`timescale 1ns/10ps
module cfbu_axi_master
   import cfbu_pkg::*;
(
   input  wire logic        clk_i,
   output logic      [7:0]  awaddr_o,
   output logic             awvalid_o,
   input  wire logic        awready_i,
   output logic      [31:0] wdata_o,
   output logic      [3:0]  wstrb_o,
   output logic             wvalid_o,
   input  wire logic        wready_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        bvalid_i,
   output logic             bready_o,
   output logic      [7:0]  araddr_o,
   output logic             arvalid_o,
   input  wire logic        arready_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic        rvalid_i,
   output logic             rready_o
);
   initial
   begin
      {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
   end
   // Ready flags are sampled at the falling edge: they come from flops and
   // cannot change before the next rising edge, so no race arises there.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      logic b;
      r = 2'b11;
      @(posedge clk_i);
      {awaddr_o, wdata_o, wstrb_o} <= {a, d, 4'hf};
      {awvalid_o, wvalid_o, bready_o} <= 3'h7;
      for (int n = 0; n < 100; n++)
      begin
         @(negedge clk_i);
         aw = awvalid_o && awready_i;
         w = wvalid_o && wready_i;
         b = bvalid_i;
         if (b) r = bresp_i;
         @(posedge clk_i);
         if (aw) awvalid_o <= 1'b0;
         if (w) wvalid_o <= 1'b0;
         if (b) bready_o <= 1'b0;
         if (b) break;
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar;
      r = 2'b11;
      @(posedge clk_i);
      araddr_o <= a;
      {arvalid_o, rready_o} <= 2'h3;
      for (int n = 0; n < 100; n++)
      begin
         @(negedge clk_i);
         ar = arvalid_o && arready_i;
         if (rvalid_i) {d, r} = {rdata_i, rresp_i};
         @(posedge clk_i);
         if (ar) arvalid_o <= 1'b0;
         if (r != 2'b11) rready_o <= 1'b0;
         if (r != 2'b11) break;
      end
   endtask
endmodule

//--- cpu_flow_control_branch_unit_tb.sv
// Self-checking bench of the flow-control unit.
`timescale 1ns/10ps
`include "cfbu_defs.svh"
`define CHK(nm, e, s) \
   begin tests_run++; if ((e) !== (s)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module cpu_flow_control_branch_unit_tb
   import cfbu_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
   logic s_axi_rvalid_o, s_axi_rready_i;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   int err_total = 0;
   int tests_run = 0;
   always #2.5 clk_i = ~clk_i;
   cfbu_top DUT (.*);
   cfbu_axi_master m (.clk_i(clk_i), .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
      .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
      .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
      .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
      .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
      .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));
   task automatic conclude();
      $display("mismatches %0d, comparisons %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // A response code of 11 marks a bus wait that ran out; the run stops there.
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      m.wr(a, d, r);
      `CHK("bresp", `CFBU_RESP_OKAY, r)
      if (r === 2'b11) conclude();
   endtask
   task automatic br(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      m.rd(a, d, r);
      `CHK("rresp", `CFBU_RESP_OKAY, r)
      if (r === 2'b11) conclude();
   endtask
   task automatic run(input logic [31:0] ins, input logic [15:0] pc, input logic [31:0] op,
      input logic [7:0] fl, input logic [15:0] epc, input logic [2:0] ecy, input logic [7:0] efl);
      logic [31:0] d;
      bw(`CFBU_OFF_PC, {16'h0, pc});
      bw(`CFBU_OFF_OPND, op);
      bw(`CFBU_OFF_FLAGS, {24'h0, fl});
      bw(`CFBU_OFF_INSTR, ins);
      bw(`CFBU_OFF_CTRL, 32'h1);
      d = 32'h1;
      for (int n = 0; n < 20 && d[`CFBU_ST_BUSY] !== 1'b0; n++)
         br(`CFBU_OFF_STATUS, d);
      `CHK("done", 1'b1, d[`CFBU_ST_DONE])
      if (d[`CFBU_ST_BUSY] !== 1'b0) conclude();
      `CHK("cycles", ecy, d[10:8])
      br(`CFBU_OFF_PC, d);
      `CHK("pc", epc, d[15:0])
      br(`CFBU_OFF_FLAGS, d);
      `CHK("flags", efl, d[7:0])
   endtask
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      br(`CFBU_OFF_STATUS, d);
      `CHK("status", 32'h0, d)
      m.rd(8'h20, d, r);
      `CHK("rresp", `CFBU_RESP_SLVERR, r)
      `CHK("rdata", 32'h0, d)
      m.wr(8'h20, 32'h1, r);
      `CHK("bresp", `CFBU_RESP_SLVERR, r)
   endtask
   task automatic t_calls();
      logic [31:0] d;
      bw(`CFBU_OFF_ZPTR, 32'h1234);
      bw(`CFBU_OFF_TARGET, 32'h0abc);
      run(32'hd005, 16'h0100, 32'h0, 8'h00, 16'h0106, `CFBU_CYC_RELATIVE_CALL, 8'h00);
      run(32'h9508, 16'h0106, 32'h0, 8'h00, 16'h0101, `CFBU_CYC_RET, 8'h00);
      run(32'hdfff, 16'h0100, 32'h0, 8'h00, 16'h0100, `CFBU_CYC_RELATIVE_CALL, 8'h00);
      run(32'h9509, 16'h0200, 32'h0, 8'h00, 16'h1234, `CFBU_CYC_ZCALL, 8'h00);
      run(32'h940e, 16'h0300, 32'h0, 8'h00, 16'h0abc, `CFBU_CYC_DCALL, 8'h00);
      run(32'h9518, 16'h0abc, 32'h0, 8'h00, 16'h0302, `CFBU_CYC_RET, 8'h80);
      run(32'h9508, 16'h0302, 32'h0, 8'h80, 16'h0201, `CFBU_CYC_RET, 8'h80);
      run(32'h9508, 16'h0201, 32'h0, 8'h00, 16'h0101, `CFBU_CYC_RET, 8'h00);
      br(`CFBU_OFF_STATUS, d);
      `CHK("stack", 4'h0, d[19:16])
   endtask
   task automatic t_compare();
      logic [31:0] d;
      run(32'h1400, 16'h0010, 32'h0110, 8'h40, 16'h0011, `CFBU_CYC_ONE, 8'h60);
      run(32'h1400, 16'h0010, 32'h0201, 8'h00, 16'h0011, `CFBU_CYC_ONE, 8'h35);
      run(32'h1400, 16'h0010, 32'h0180, 8'h00, 16'h0011, `CFBU_CYC_ONE, 8'h38);
      run(32'h1400, 16'h0010, 32'h5555, 8'h00, 16'h0011, `CFBU_CYC_ONE, 8'h02);
      run(32'h0400, 16'h0010, 32'h5555, 8'h03, 16'h0011, `CFBU_CYC_ONE, 8'h35);
      run(32'h0400, 16'h0010, 32'h5555, 8'h00, 16'h0011, `CFBU_CYC_ONE, 8'h00);
      run(32'h0400, 16'h0010, 32'h5555, 8'h02, 16'h0011, `CFBU_CYC_ONE, 8'h02);
      run(32'h355a, 16'h0010, 32'h005a, 8'h00, 16'h0011, `CFBU_CYC_ONE, 8'h02);
      br(`CFBU_OFF_OPND, d);
      `CHK("opnd", 32'h005a, d)
   endtask
   task automatic t_skips();
      logic [31:0] d;
      run(32'h01000, 16'h20, 32'h3333, 8'h3f, 16'h22, `CFBU_CYC_SKIP1, 8'h3f);
      br(`CFBU_OFF_STATUS, d);
      `CHK("hit", 1'b1, d[`CFBU_ST_HIT])
      run(32'h11000, 16'h20, 32'h3333, 8'h3f, 16'h23, `CFBU_CYC_SKIP2, 8'h3f);
      run(32'h01000, 16'h20, 32'h3433, 8'h3f, 16'h21, `CFBU_CYC_ONE, 8'h3f);
      run(32'h0fc03, 16'h20, 32'h0008, 8'h00, 16'h21, `CFBU_CYC_ONE, 8'h00);
      run(32'h0fe03, 16'h20, 32'h0008, 8'h00, 16'h22, `CFBU_CYC_SKIP1, 8'h00);
      run(32'h0fc03, 16'h20, 32'h00f7, 8'h00, 16'h22, `CFBU_CYC_SKIP1, 8'h00);
      run(32'h09907, 16'h20, 32'h800000, 8'h00, 16'h21, `CFBU_CYC_ONE, 8'h00);
      run(32'h19b07, 16'h20, 32'h800000, 8'h3f, 16'h23, `CFBU_CYC_SKIP2, 8'h3f);
      run(32'h09b07, 16'h20, 32'h7fffff, 8'h3f, 16'h21, `CFBU_CYC_ONE, 8'h3f);
   endtask
   task automatic t_illegal();
      logic [31:0] d;
      run(32'h0000, 16'h0040, 32'h0, 8'h5a, 16'h0041, `CFBU_CYC_ONE, 8'h5a);
      br(`CFBU_OFF_STATUS, d);
      `CHK("illegal", 1'b1, d[`CFBU_ST_ILLEGAL])
      `CHK("hit", 1'b0, d[`CFBU_ST_HIT])
   endtask
   // Flag index 4 judges N xor V, so a lone stored S bit must not take the branch.
   task automatic t_branches();
      logic [7:0] f;
      logic [15:0] hit;
      logic [15:0] miss;
      logic [15:0] w;
      logic [2:0] s;
      logic [2:0] cy;
      logic [2:0] cn;
      for (int i = 0; i < 8; i++)
      begin
         s = i[2:0];
         f = 8'h01 << s;
         w = 16'hf020 | {13'h0, s};
         hit = (s != 3'h4) ? 16'h0105 : 16'h0101;
         miss = (s != 3'h4) ? 16'h0101 : 16'h0105;
         cy = (s != 3'h4) ? `CFBU_CYC_BRANCH : `CFBU_CYC_ONE;
         cn = (s != 3'h4) ? `CFBU_CYC_ONE : `CFBU_CYC_BRANCH;
         run({16'h0, w}, 16'h0100, 32'h0, f, hit, cy, f);
         run({16'h0, w | 16'h0400}, 16'h0100, 32'h0, f, miss, cn, f);
      end
      run(32'hf024, 16'h0100, 32'h0, 8'h04, 16'h0105, `CFBU_CYC_BRANCH, 8'h04);
      run(32'hf024, 16'h0100, 32'h0, 8'h0c, 16'h0101, `CFBU_CYC_ONE, 8'h0c);
      run(32'hf424, 16'h0100, 32'h0, 8'h1c, 16'h0105, `CFBU_CYC_BRANCH, 8'h1c);
      run(32'hf3f8, 16'h0100, 32'h0, 8'h01, 16'h0100, `CFBU_CYC_BRANCH, 8'h01);
   endtask
   initial
   begin
      rst_b_i = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_calls();
      t_compare();
      t_skips();
      t_branches();
      t_illegal();
      conclude();
   end
endmodule
